// ===== rtl/ospg_pkg.sv
package ospg_pkg;

  // ==========================================================================
  // Clock and timing.
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned OV_TRIP_NS       = 200;
  localparam int unsigned OV_TRIP_CYC      = (OV_TRIP_NS * CLK_MHZ) / 1000;
  localparam int unsigned PG_STEP_MS       = 1;
  localparam int unsigned PG_STEP_CYC_DEF  = PG_STEP_MS * CLK_MHZ * 1000;
  localparam int unsigned PG_DLY_MAX       = 10;

  // ==========================================================================
  // Voltages in 1/256 V counts.
  localparam logic [15:0] V_FINAL_REF      = 16'h0080;
  localparam logic [15:0] PG_ON_DEF        = 16'h0073;
  localparam logic [15:0] PG_OFF_DEF       = 16'h006B;
  localparam logic [15:0] OV_DEF           = 16'h009B;
  localparam logic [15:0] PG_OFFSET        = 16'h00A1;
  localparam logic [15:0] OV_OFFSET        = 16'h00A8;
  localparam logic [15:0] RAMP_STEP        = 16'h0001;

  // ==========================================================================
  // APB register map.
  localparam logic [7:0] ADDR_CTRL         = 8'h00;
  localparam logic [7:0] ADDR_PG_ON        = 8'h04;
  localparam logic [7:0] ADDR_PG_OFF       = 8'h08;
  localparam logic [7:0] ADDR_OV_LIM       = 8'h0C;
  localparam logic [7:0] ADDR_UV_FLT       = 8'h10;
  localparam logic [7:0] ADDR_UV_WRN       = 8'h14;
  localparam logic [7:0] ADDR_OV_WRN       = 8'h18;
  localparam logic [7:0] ADDR_VOUT         = 8'h1C;
  localparam logic [7:0] ADDR_STATUS       = 8'h20;
  localparam logic [7:0] ADDR_MASK         = 8'h24;
  localparam logic [7:0] ADDR_STATE        = 8'h28;

  // CTRL fields.
  localparam int unsigned CTRL_DIGITAL     = 0;
  localparam int unsigned CTRL_OV_IGNORE   = 1;
  localparam int unsigned CTRL_OP_RESTART  = 2;
  localparam int unsigned CTRL_DLY_LSB     = 4;
  localparam int unsigned CTRL_DLY_W       = 4;

  // Status bits.
  localparam int unsigned ST_OV_FLT        = 0;
  localparam int unsigned ST_OV_WRN        = 1;
  localparam int unsigned ST_UV_FLT        = 2;
  localparam int unsigned ST_UV_WRN        = 3;
  localparam int unsigned ST_W             = 4;

  localparam logic [15:0] UV_FLT_DEF       = 16'h0060;
  localparam logic [15:0] UV_WRN_DEF       = 16'h0066;
  localparam logic [15:0] OV_WRN_DEF       = 16'h0095;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ospg_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } ospg_apb_rsp_s;

endpackage : ospg_pkg

// ===== rtl/ospg_supervisor.sv
// Function
// - Tracking pin low selects tracking; floating pin selects sequencing.
// - Regulate to the lower of tracking reference input and internal ramp.
// - After enable rises, ramp internal reference up to final 0.5 V.
// - Sequencing: once tracking input exceeds ramp, regulate to ramp.
// - Report digitized sense voltage in 1/256 V counts.
// - Digitized sense sets OV warning, UV fault and UV warning flags.
// - Power good high while sense lies inside window; defaults 0.45/0.42 V.
// - Digital mode: power-good on and off thresholds come from registers.
// - Thresholds further than 630 mV from output track output at 630 mV.
// - Power good delay zero by default; digital mode 0 to 10 ms.
// - Default OV threshold 0.605 V; tracking uses 1.2 times tracking input.
// - Digital non-tracking: OV limit register, capped at output plus 655 mV.
// - Overvoltage trip asserts about 200 ns after sense exceeds threshold.
// - Default OV response latches high side off and forces power good low.
// - Low side stays on while sense stays above the threshold.
// - High side latch clears only by enable cycling or restart command.
// - Ignore response keeps converting but still sets status and alert.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ospg_supervisor
  import ospg_pkg::*;
#(
  parameter int unsigned PG_STEP_CYC = PG_STEP_CYC_DEF
) (
  input  wire logic          i_clk_sys,
  input  wire logic          i_nrst,
  input  wire ospg_apb_req_s i_apb,
  output ospg_apb_rsp_s      o_apb,
  input  wire logic          i_enable,
  input  wire logic          i_tracking_enable,
  input  wire logic [15:0]   i_tracking_reference_input,
  input  wire logic [15:0]   i_vsense,
  output logic [15:0]        o_internal_reference_ramp,
  output logic [15:0]        o_active_reference,
  output logic               o_high_side_drive_en,
  output logic               o_low_side_force,
  output logic               o_power_good_output_oe,
  output logic               o_alert_output_oe,
  output logic               o_irq
);

  // ==========================================================================
  // State.
  typedef struct packed {
    logic [1:0]  en_sync;
    logic [1:0]  trk_sync;
    logic        en_d;
    logic [31:0] ctrl;
    logic [15:0] pg_on;
    logic [15:0] pg_off;
    logic [15:0] ov_lim;
    logic [15:0] uv_flt;
    logic [15:0] uv_wrn;
    logic [15:0] ov_wrn;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
    logic [15:0] ramp;
    logic [15:0] vout;
    logic [7:0]  ov_cnt;
    logic        ov_trip;
    logic        hs_latched;
    logic        pg_in;
    logic        pg;
    logic [31:0] step_cnt;
    logic [3:0]  ms_cnt;
    logic [31:0] rdata;
  } ospg_state_s;

  ospg_state_s st;
  ospg_state_s next_st;

  logic        en_s;
  logic        tracking;
  logic        digital;
  logic [15:0] trk_in;
  logic [15:0] pg_hi;
  logic [15:0] pg_lo;
  logic [15:0] ov_thr;
  logic [17:0] ov_trk;
  logic        ov_above;
  logic        in_win;
  logic [3:0]  dly_set;
  logic        wr_acc;
  logic        rd_acc;
  logic        mapped;

  assign en_s     = st.en_sync[1];
  assign tracking = ~st.trk_sync[1];
  assign digital  = st.ctrl[CTRL_DIGITAL];
  assign trk_in   = i_tracking_reference_input;
  assign wr_acc   = i_apb.psel & i_apb.penable & i_apb.pwrite;
  assign rd_acc   = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
  assign mapped   = (i_apb.paddr <= ADDR_STATE) && (i_apb.paddr[1:0] == 2'b00);
  assign ov_trk   = {2'b00, trk_in} + {1'b0, trk_in, 1'b0} / 18'd10;

  // ==========================================================================
  // Thresholds.
  always_comb begin
    pg_hi = PG_ON_DEF;
    pg_lo = PG_OFF_DEF;
    // The offsets follow the regulated target, not the sensed level: a
    // cap that followed the sense itself could never be crossed.
    if (digital) begin
      pg_hi = st.pg_on;
      pg_lo = st.pg_off;
      if (pg_hi > o_active_reference + PG_OFFSET) begin
        pg_hi = o_active_reference + PG_OFFSET;
      end
      if (o_active_reference > PG_OFFSET &&
          pg_lo < o_active_reference - PG_OFFSET) begin
        pg_lo = o_active_reference - PG_OFFSET;
      end
    end
    if (tracking) begin
      ov_thr = (ov_trk > 18'h0_FFFF) ? 16'hFFFF
                                     : ov_trk[15:0];
    end else if (digital) begin
      ov_thr = st.ov_lim;
      if (ov_thr > o_active_reference + OV_OFFSET) begin
        ov_thr = o_active_reference + OV_OFFSET;
      end
    end else begin
      ov_thr = OV_DEF;
    end
  end

  assign ov_above = i_vsense > ov_thr;
  // The falling threshold gives hysteresis once the sense has entered the window.
  assign in_win   = (i_vsense <= ov_thr) &&
                    (i_vsense >= (st.pg_in ? pg_lo : pg_hi));
  assign dly_set  = digital ? st.ctrl[CTRL_DLY_LSB +: CTRL_DLY_W] : 4'h0;

  // ==========================================================================
  // Next state.
  always_comb begin
    next_st          = st;
    next_st.en_sync  = {st.en_sync[0], i_enable};
    next_st.trk_sync = {st.trk_sync[0], i_tracking_enable};
    next_st.en_d     = en_s;
    next_st.vout     = i_vsense;
    next_st.ctrl[CTRL_OP_RESTART] = 1'b0;

    if (!en_s) begin
      next_st.ramp = 16'h0000;
    end else if (st.ramp < V_FINAL_REF) begin
      next_st.ramp = st.ramp + RAMP_STEP;
    end

    if (ov_above) begin
      if (st.ov_cnt >= 8'(OV_TRIP_CYC - 1)) begin
        next_st.ov_trip = 1'b1;
      end else begin
        next_st.ov_cnt = st.ov_cnt + 8'h01;
      end
    end else begin
      next_st.ov_cnt  = 8'h00;
      next_st.ov_trip = 1'b0;
    end

    if ((en_s && !st.en_d) || st.ctrl[CTRL_OP_RESTART]) begin
      next_st.hs_latched = 1'b0;
    end
    if (st.ov_trip && !st.ctrl[CTRL_OV_IGNORE]) begin
      next_st.hs_latched = 1'b1;
    end

    next_st.pg_in = in_win && !st.ov_trip;
    if (!next_st.pg_in) begin
      next_st.pg       = 1'b0;
      next_st.ms_cnt   = 4'h0;
      next_st.step_cnt = 32'h0;
    end else if (!st.pg) begin
      if (st.ms_cnt >= dly_set) begin
        next_st.pg = 1'b1;
      end else if (st.step_cnt >= PG_STEP_CYC - 1) begin
        next_st.step_cnt = 32'h0;
        next_st.ms_cnt   = st.ms_cnt + 4'h1;
      end else begin
        next_st.step_cnt = st.step_cnt + 32'h1;
      end
    end

    if (wr_acc && mapped) begin
      unique case (i_apb.paddr)
        ADDR_CTRL: begin
          next_st.ctrl = i_apb.pwdata;
          if (i_apb.pwdata[CTRL_DLY_LSB +: CTRL_DLY_W] > 4'(PG_DLY_MAX)) begin
            next_st.ctrl[CTRL_DLY_LSB +: CTRL_DLY_W] = 4'(PG_DLY_MAX);
          end
        end
        ADDR_PG_ON:  next_st.pg_on  = i_apb.pwdata[15:0];
        ADDR_PG_OFF: next_st.pg_off = i_apb.pwdata[15:0];
        ADDR_OV_LIM: next_st.ov_lim = i_apb.pwdata[15:0];
        ADDR_UV_FLT: next_st.uv_flt = i_apb.pwdata[15:0];
        ADDR_UV_WRN: next_st.uv_wrn = i_apb.pwdata[15:0];
        ADDR_OV_WRN: next_st.ov_wrn = i_apb.pwdata[15:0];
        ADDR_STATUS: next_st.status = st.status & ~i_apb.pwdata[ST_W-1:0];
        ADDR_MASK:   next_st.mask   = i_apb.pwdata[ST_W-1:0];
        default: begin
        end
      endcase
    end

    // Set wins over a clear in the same cycle.
    if (st.ov_trip) next_st.status[ST_OV_FLT] = 1'b1;
    if (en_s && st.ramp >= V_FINAL_REF) begin
      if (st.vout > st.ov_wrn) next_st.status[ST_OV_WRN] = 1'b1;
      if (st.vout < st.uv_flt) next_st.status[ST_UV_FLT] = 1'b1;
      if (st.vout < st.uv_wrn) next_st.status[ST_UV_WRN] = 1'b1;
    end

    next_st.rdata = 32'h0000_0000;
    if (rd_acc) begin
      unique case (i_apb.paddr)
        ADDR_CTRL:   next_st.rdata = st.ctrl;
        ADDR_PG_ON:  next_st.rdata = {16'h0000, st.pg_on};
        ADDR_PG_OFF: next_st.rdata = {16'h0000, st.pg_off};
        ADDR_OV_LIM: next_st.rdata = {16'h0000, st.ov_lim};
        ADDR_UV_FLT: next_st.rdata = {16'h0000, st.uv_flt};
        ADDR_UV_WRN: next_st.rdata = {16'h0000, st.uv_wrn};
        ADDR_OV_WRN: next_st.rdata = {16'h0000, st.ov_wrn};
        ADDR_VOUT:   next_st.rdata = {16'h0000, st.vout};
        ADDR_STATUS: next_st.rdata = {28'h000_0000, st.status};
        ADDR_MASK:   next_st.rdata = {28'h000_0000, st.mask};
        ADDR_STATE:  next_st.rdata = {26'h000_0000, tracking, st.pg,
                                      st.hs_latched, st.ov_trip, en_s, digital};
        default:     next_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st        <= '0;
      st.pg_on  <= PG_ON_DEF;
      st.pg_off <= PG_OFF_DEF;
      st.ov_lim <= OV_DEF;
      st.uv_flt <= UV_FLT_DEF;
      st.uv_wrn <= UV_WRN_DEF;
      st.ov_wrn <= OV_WRN_DEF;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================================
  // Outputs.
  assign o_internal_reference_ramp = st.ramp;
  assign o_active_reference =
    (!tracking && trk_in > st.ramp) ? st.ramp :
    ((trk_in < st.ramp) ? trk_in : st.ramp);
  assign o_high_side_drive_en = en_s && !st.hs_latched;
  assign o_low_side_force = st.ov_trip;
  // Open drain: enable pulls low; the pull-up is outside.
  assign o_power_good_output_oe = ~st.pg;
  assign o_irq = |(st.status & st.mask);
  assign o_alert_output_oe = |st.status;
  assign o_apb = '{pready:  1'b1,
                   pslverr: i_apb.psel & i_apb.penable & ~mapped,
                   prdata:  st.rdata};

  // ==========================================================================
  // Assertions.
  property p_ov_trip_delay;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (!ov_above ##1 ov_above [*8] ##1 ov_above [*8] ##1 ov_above [*8]
        ##1 ov_above) |=> st.ov_trip;
  endproperty
  a_ov_trip_delay: assert property (p_ov_trip_delay)
    else $error("Overvoltage trip late.");

  // Three runs of eight make 24 cycles, one short of the trip delay.
  property p_ov_trip_early;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (!ov_above ##1 ov_above [*8] ##1 ov_above [*8] ##1 ov_above [*8])
        |-> !st.ov_trip;
  endproperty
  a_ov_trip_early: assert property (p_ov_trip_early)
    else $error("Overvoltage trip early.");

  property p_hs_latch;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (st.ov_trip && !st.ctrl[CTRL_OV_IGNORE]) |=> !o_high_side_drive_en;
  endproperty
  a_hs_latch: assert property (p_hs_latch)
    else $error("High side not latched off.");

  property p_ls_release;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !ov_above |=> !o_low_side_force;
  endproperty
  a_ls_release: assert property (p_ls_release)
    else $error("Low side held after recovery.");

  property p_ignore;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (st.ov_trip && st.ctrl[CTRL_OV_IGNORE] && !st.hs_latched && en_s)
        |=> st.status[ST_OV_FLT] && o_alert_output_oe;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("Ignored overvoltage not flagged.");

  property p_pg_out;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !next_st.pg_in |=> !st.pg && o_power_good_output_oe;
  endproperty
  a_pg_out: assert property (p_pg_out)
    else $error("Power good outside window.");

  property p_pg_nodelay;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (dly_set == 4'h0 && next_st.pg_in) |=> st.pg;
  endproperty
  a_pg_nodelay: assert property (p_pg_nodelay)
    else $error("Power good delayed with zero setting.");

  property p_pg_restart;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      !st.pg_in |-> st.ms_cnt == 4'h0;
  endproperty
  a_pg_restart: assert property (p_pg_restart)
    else $error("Delay counter not restarted.");

  property p_ref_min;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      o_active_reference <= st.ramp;
  endproperty
  a_ref_min: assert property (p_ref_min)
    else $error("Active reference above ramp.");

  property p_ramp_cap;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      st.ramp <= V_FINAL_REF;
  endproperty
  a_ramp_cap: assert property (p_ramp_cap)
    else $error("Ramp overshoots final reference.");

  property p_vout;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      1'b1 |=> st.vout == $past(i_vsense);
  endproperty
  a_vout: assert property (p_vout)
    else $error("Reported output voltage stale.");

  c_ov_trip: cover property (@(posedge i_clk_sys) st.ov_trip);
  c_pg_up: cover property (@(posedge i_clk_sys) $rose(st.pg));
  c_restart: cover property (@(posedge i_clk_sys) $fell(st.hs_latched));

endmodule : ospg_supervisor

`default_nettype wire

// ===== test/ospg_plant_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Output stage and board stand-in.
// Sense follows the regulated reference only while the high side may
// switch, so a latched-off stage really collapses the output. The bench
// can override the level to inject faults.
module ospg_plant_model
  import ospg_pkg::*;
(
  input  wire logic [15:0] i_active_reference,
  input  wire logic        i_high_side_drive_en,
  input  wire logic        i_power_good_output_oe,
  input  wire logic        i_override,
  input  wire logic [15:0] i_override_level,
  input  wire logic        i_track_pin_tied_low,
  output logic [15:0]      o_vsense,
  output logic             o_tracking_enable,
  output logic             o_power_good_wire
);
  assign o_vsense = i_override ? i_override_level :
                    (i_high_side_drive_en ? i_active_reference : 16'h0000);
  // A floating pin is pulled up internally.
  assign o_tracking_enable = ~i_track_pin_tied_low;
  // The board pull-up holds the line high unless it is pulled low.
  assign o_power_good_wire = ~i_power_good_output_oe;
endmodule // ospg_plant_model

`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import ospg_pkg::*;
;
  // A short delay step keeps the longest delay test to a few dozen cycles.
  localparam int unsigned STEP = 10;
  logic          i_clk_sys;
  logic          i_nrst;
  ospg_apb_req_s req;
  ospg_apb_rsp_s rsp;
  logic          en, tie_low, ovr, trk_en, hs, ls, pg_oe, al_oe, irq, pg_w;
  logic [15:0]   lvl, trk, vs, ramp, aref;
  logic [31:0]   rdata;
  logic          err;
  int            failures, samples_checked;
  logic [7:0]    ra [6] = '{ADDR_PG_ON, ADDR_PG_OFF, ADDR_OV_LIM,
                            ADDR_UV_FLT, ADDR_UV_WRN, ADDR_OV_WRN};
  logic [15:0]   rv [6] = '{PG_ON_DEF, PG_OFF_DEF, OV_DEF,
                            UV_FLT_DEF, UV_WRN_DEF, OV_WRN_DEF};

  ospg_supervisor #(.PG_STEP_CYC(STEP)) dut (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_apb(req), .o_apb(rsp),
    .i_enable(en), .i_tracking_enable(trk_en),
    .i_tracking_reference_input(trk), .i_vsense(vs),
    .o_internal_reference_ramp(ramp), .o_active_reference(aref),
    .o_high_side_drive_en(hs), .o_low_side_force(ls),
    .o_power_good_output_oe(pg_oe), .o_alert_output_oe(al_oe), .o_irq(irq));

  ospg_plant_model plant (
    .i_active_reference(aref),
    .i_high_side_drive_en(hs), .i_power_good_output_oe(pg_oe),
    .i_override(ovr), .i_override_level(lvl),
    .i_track_pin_tied_low(tie_low), .o_vsense(vs),
    .o_tracking_enable(trk_en), .o_power_good_wire(pg_w));

  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // The wait for pready is bounded; a silent slave ends the run.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge i_clk_sys);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (rsp.pready !== 1'b1) begin
      failures++;
      wrap_up();
    end
    rdata = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  // ==========================================================================
  // Main sequence.
  initial begin
    i_nrst = 1'b0;
    req = '0;
    en = 1'b0;
    tie_low = 1'b0;
    ovr = 1'b0;
    lvl = 16'h0000;
    trk = 16'hFFFF;
    failures = 0;
    samples_checked = 0;
    cyc(6);
    chk(pg_w, 1'b0, "pg in reset");
    i_nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0000_0000);
      chk(rdata, {16'h0000, rv[i]}, "default");
    end
    apb(1'b0, 8'h2C, 32'h0000_0000);
    chk(err, 1'b1, "unmapped");
    $display("test defaults done");

    en <= 1'b1;
    for (int n = 0; n < 5000 && ramp !== V_FINAL_REF; n++) cyc(1);
    chk(ramp, V_FINAL_REF, "ramp end");
    chk(aref, V_FINAL_REF, "lower ref");
    $display("test ramp done");

    ovr <= 1'b1;
    lvl <= 16'h006F;
    cyc(4);
    chk(pg_w, 1'b1, "pg in window");
    lvl <= 16'h005F;
    cyc(4);
    chk(pg_w, 1'b0, "pg below");
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdata & 32'h0000_000C, 32'h0000_000C, "uv flags");
    apb(1'b0, ADDR_VOUT, 32'h0000_0000);
    chk(rdata, 32'h0000_005F, "vout");
    $display("test window done");

    // Power good is down here, so the level must pass the rising threshold.
    apb(1'b1, ADDR_CTRL, 32'h0000_0021);
    lvl <= 16'h0078;
    cyc(12);
    chk(pg_w, 1'b0, "pg early");
    lvl <= 16'h005F;
    cyc(2);
    lvl <= 16'h0078;
    cyc(15);
    chk(pg_w, 1'b0, "pg restart");
    cyc(15);
    chk(pg_w, 1'b1, "pg delayed");
    $display("test delay done");

    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_STATUS, 32'h0000_000F);
    apb(1'b1, ADDR_MASK, 32'h0000_0001);
    lvl <= 16'h00A0;
    cyc(20);
    chk(ls, 1'b0, "trip early");
    cyc(15);
    chk(ls, 1'b1, "low side");
    chk(hs, 1'b0, "hs latched");
    chk(pg_w, 1'b0, "pg forced");
    chk(irq, 1'b1, "irq");
    lvl <= 16'h0080;
    cyc(4);
    chk(ls, 1'b0, "low side off");
    chk(hs, 1'b0, "hs held");
    apb(1'b1, ADDR_STATUS, 32'h0000_000F);
    cyc(2);
    chk(irq, 1'b0, "irq clr");
    chk(al_oe, 1'b0, "alert clr");
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    cyc(3);
    chk(hs, 1'b1, "restart");
    $display("test ov latch done");

    apb(1'b1, ADDR_MASK, 32'h0000_0000);
    apb(1'b1, ADDR_OV_LIM, 32'h0000_0090);
    apb(1'b1, ADDR_CTRL, 32'h0000_0003);
    lvl <= 16'h0094;
    cyc(35);
    chk(hs, 1'b1, "ignore");
    chk(al_oe, 1'b1, "alert");
    chk(irq, 1'b0, "masked");
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rdata & 32'h0000_0001, 32'h0000_0001, "ov flag");
    // A limit far above the target is capped 655 mV above it.
    lvl <= 16'h0080;
    apb(1'b1, ADDR_OV_LIM, 32'h0000_0200);
    lvl <= 16'h0130;
    cyc(35);
    chk(ls, 1'b1, "ov cap");
    $display("test ov ignore done");

    lvl <= 16'h0040;
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    tie_low <= 1'b1;
    trk <= 16'h0040;
    cyc(5);
    chk(aref, 16'h0040, "track ref");
    apb(1'b0, ADDR_STATE, 32'h0000_0000);
    chk(rdata & 32'h0000_0020, 32'h0000_0020, "tracking");
    lvl <= 16'h004E;
    cyc(35);
    chk(ls, 1'b1, "track ov");
    chk(hs, 1'b0, "track latch");
    tie_low <= 1'b0;
    trk <= 16'h0090;
    cyc(5);
    chk(aref, V_FINAL_REF, "sequence");
    en <= 1'b0;
    cyc(4);
    en <= 1'b1;
    cyc(5);
    chk(hs, 1'b1, "enable cycle");
    $display("test tracking done");
    wrap_up();
  end
endmodule // tb_top

`default_nettype wire
